/* File: rtl/lqta_pkg.sv */
package lqta_pkg;
  // Register location and width
  localparam logic [4:0] LQTA_REG_ADDR = 5'h1e;
  localparam int LQTA_REG_W = 16;
  localparam logic [15:0] LQTA_REG_RESET = 16'h0000;
  // Field positions
  localparam int LQTA_SAMPLE_BIT = 13;
  localparam int LQTA_WSTROBE_BIT = 12;
  localparam int LQTA_PSEL_HI = 11;
  localparam int LQTA_PSEL_LO = 9;
  localparam int LQTA_BOUND_BIT = 8;
  localparam int LQTA_DATA_HI = 7;
  // Parameter encodings
  localparam logic [2:0] LQTA_P_EQ = 3'h0;
  localparam logic [2:0] LQTA_P_GAIN = 3'h1;
  localparam logic [2:0] LQTA_P_BLW = 3'h2;
  localparam logic [2:0] LQTA_P_FOFS = 3'h3;
  localparam logic [2:0] LQTA_P_FCTL = 3'h4;
  localparam int LQTA_NUM_PARAM = 5;
  // Threshold reset values: low bound minimum, high bound maximum (check disabled)
  localparam logic [7:0] LQTA_LO_RESET = 8'h00;
  localparam logic [7:0] LQTA_HI_RESET = 8'hff;
  localparam logic [7:0] LQTA_MIN = 8'h00;
  localparam logic [7:0] LQTA_MAX = 8'hff;
endpackage

/* File: rtl/lqta_regs.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Threshold writes refused during power-down
// - Bits 15:14 ignore writes, read zero
// - Sample bit captures parameter, switches readback
// - Write strobe copies data into selected threshold
// - Write strobe self-clears, always reads zero
// - Select codes: equalizer, gain, wander, offset, control
// - One select drives sampling and threshold access
// - Bound bit picks low/high of ten thresholds
// - Sample clear: written data is threshold content
// - Sample clear: read returns stored threshold
// - Sample set: read returns sampled value
// - Sampled value held until new read sequence
// - Monitor active only with valid 100M link
// - Extreme threshold values disable that check
// - Crossing raises matching warning
module lqta_regs
  import lqta_pkg::*;
#(
  parameter int NUM_PARAM = LQTA_NUM_PARAM
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  // Register access
  input wire logic [4:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  // Device state
  input wire logic power_down,
  input wire logic link_100_valid,
  input wire logic monitor_enable,
  // Live adapted parameters, packed by index
  input wire logic [NUM_PARAM*8-1:0] param_live,
  // Monitor outputs
  output logic monitor_active,
  output logic [2*NUM_PARAM-1:0] warn_hit
);

  initial begin
    if (NUM_PARAM != LQTA_NUM_PARAM) begin
      $error("NUM_PARAM must equal the five documented parameters");
    end
  end

  logic sample_mode;
  logic [2:0] parameter_select;
  logic bound_select;
  logic [7:0] threshold_value_field;
  logic [7:0] sampled;
  logic [7:0] thr_lo [NUM_PARAM];
  logic [7:0] thr_hi [NUM_PARAM];
  logic next_sample_mode;
  logic [2:0] next_parameter_select;
  logic next_bound_select;
  logic [7:0] next_threshold_value_field;
  logic [7:0] next_sampled;
  logic [7:0] next_thr_lo [NUM_PARAM];
  logic [7:0] next_thr_hi [NUM_PARAM];
  logic reg_hit;
  logic threshold_write_strobe;
  logic sel_valid;
  logic [7:0] live_sel;
  logic [7:0] thr_sel;

  assign reg_hit = reg_addr == LQTA_REG_ADDR;
  assign sel_valid = parameter_select < 3'(NUM_PARAM);
  assign threshold_write_strobe = clk_en && reg_hit && reg_wr &&
    reg_wdata[LQTA_WSTROBE_BIT] && !power_down;

  // Parameter decode: equalizer, gain, wander, offset, control
  always_comb begin
    live_sel = 8'h00;
    case (reg_wdata[LQTA_PSEL_HI:LQTA_PSEL_LO])
      LQTA_P_EQ: live_sel = param_live[7:0];
      LQTA_P_GAIN: live_sel = param_live[15:8];
      LQTA_P_BLW: live_sel = param_live[23:16];
      LQTA_P_FOFS: live_sel = param_live[31:24];
      LQTA_P_FCTL: live_sel = param_live[39:32];
      default: live_sel = 8'h00;
    endcase
  end

  // Control fields
  always_comb begin
    next_sample_mode = sample_mode;
    next_parameter_select = parameter_select;
    next_bound_select = bound_select;
    next_threshold_value_field = threshold_value_field;
    next_sampled = sampled;
    if (clk_en && reg_hit && reg_wr) begin
      next_sample_mode = reg_wdata[LQTA_SAMPLE_BIT];
      next_parameter_select = reg_wdata[LQTA_PSEL_HI:LQTA_PSEL_LO];
      next_bound_select = reg_wdata[LQTA_BOUND_BIT];
      next_threshold_value_field = reg_wdata[LQTA_DATA_HI:0];
      if (reg_wdata[LQTA_SAMPLE_BIT]) begin
        next_sampled = live_sel;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sample_mode <= 1'b0;
      parameter_select <= 3'h0;
      bound_select <= 1'b0;
      threshold_value_field <= 8'h00;
      sampled <= 8'h00;
    end else begin
      sample_mode <= next_sample_mode;
      parameter_select <= next_parameter_select;
      bound_select <= next_bound_select;
      threshold_value_field <= next_threshold_value_field;
      sampled <= next_sampled;
    end
  end

  // Threshold storage, ten entries
  generate
    for (genvar p = 0; p < NUM_PARAM; p++) begin : g_thr
      always_comb begin
        next_thr_lo[p] = thr_lo[p];
        next_thr_hi[p] = thr_hi[p];
        if (threshold_write_strobe &&
            reg_wdata[LQTA_PSEL_HI:LQTA_PSEL_LO] == 3'(p)) begin
          if (reg_wdata[LQTA_BOUND_BIT]) begin
            next_thr_hi[p] = reg_wdata[LQTA_DATA_HI:0];
          end else begin
            next_thr_lo[p] = reg_wdata[LQTA_DATA_HI:0];
          end
        end
      end
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          thr_lo[p] <= LQTA_LO_RESET;
          thr_hi[p] <= LQTA_HI_RESET;
        end else begin
          thr_lo[p] <= next_thr_lo[p];
          thr_hi[p] <= next_thr_hi[p];
        end
      end
      // Comparison, gated by link and enable; extremes disable a check
      assign warn_hit[2*p] = monitor_active && thr_lo[p] != LQTA_MIN &&
        param_live[p*8 +: 8] < thr_lo[p];
      assign warn_hit[2*p+1] = monitor_active && thr_hi[p] != LQTA_MAX &&
        param_live[p*8 +: 8] > thr_hi[p];
    end
  endgenerate

  assign monitor_active = monitor_enable && link_100_valid;

  // Read path
  assign thr_sel = !sel_valid ? 8'h00 :
    (bound_select ? thr_hi[parameter_select] : thr_lo[parameter_select]);
  always_comb begin
    reg_rdata = 16'h0000;
    reg_rdata[LQTA_SAMPLE_BIT] = sample_mode;
    reg_rdata[LQTA_PSEL_HI:LQTA_PSEL_LO] = parameter_select;
    reg_rdata[LQTA_BOUND_BIT] = bound_select;
    reg_rdata[LQTA_DATA_HI:0] = sample_mode ? sampled : thr_sel;
    if (!reg_hit) begin
      reg_rdata = 16'h0000;
    end
  end

  // Checks
  wr_blocked_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    reg_hit && reg_wr && clk_en && power_down |=> $stable(thr_lo[0]) && $stable(thr_hi[0]))
    else $error("threshold changed during power-down");
  resv_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    reg_rdata[15:14] == 2'b00 && reg_rdata[LQTA_WSTROBE_BIT] == 1'b0)
    else $error("reserved or strobe bit read nonzero");
  sample_cap_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && reg_hit && reg_wr && reg_wdata[LQTA_SAMPLE_BIT] &&
    reg_wdata[LQTA_PSEL_HI:LQTA_PSEL_LO] == LQTA_P_GAIN
    |=> sampled == $past(param_live[15:8]))
    else $error("sampled gain not returned");
  thr_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    threshold_write_strobe && reg_wdata[11:8] == 4'h1
    |=> thr_hi[0] == $past(reg_wdata[7:0]))
    else $error("threshold write lost");
  thr_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    reg_hit && !sample_mode && parameter_select == LQTA_P_FCTL && !bound_select
    |-> reg_rdata[7:0] == thr_lo[4])
    else $error("threshold readback wrong");
  sample_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    reg_hit && sample_mode && !(reg_wr && clk_en) |=> $stable(sampled))
    else $error("sample changed without new read");
  mon_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !link_100_valid |-> warn_hit == '0)
    else $error("warning without link");
  max_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    thr_hi[2] == LQTA_MAX |-> !warn_hit[5])
    else $error("disabled check fired");

  // Write gating and refusal
  strobe_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    threshold_write_strobe |-> clk_en && reg_hit && reg_wr && !power_down)
    else $error("threshold write strobe without a qualified write");

  pd_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    power_down |=> $stable(thr_lo[4]) && $stable(thr_hi[4]))
    else $error("frequency control threshold changed during power-down");

  resv_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && reg_hit && reg_wr && reg_wdata[15:14] != 2'b00 |=> reg_rdata[15:14] == 2'b00)
    else $error("reserved bits kept written value");

  off_addr_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !reg_hit |-> reg_rdata == 16'h0000)
    else $error("read data driven for another address");

  // Sampling of live parameters
  sample_mode_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && reg_hit && reg_wr |=> sample_mode == $past(reg_wdata[LQTA_SAMPLE_BIT]))
    else $error("sample mode not taken from write");

  sample_eq_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && reg_hit && reg_wr && reg_wdata[LQTA_SAMPLE_BIT] &&
    reg_wdata[LQTA_PSEL_HI:LQTA_PSEL_LO] == LQTA_P_EQ
    |=> sampled == $past(param_live[7:0]))
    else $error("sampled equalizer value wrong");

  sample_blw_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && reg_hit && reg_wr && reg_wdata[LQTA_SAMPLE_BIT] &&
    reg_wdata[LQTA_PSEL_HI:LQTA_PSEL_LO] == LQTA_P_BLW
    |=> sampled == $past(param_live[23:16]))
    else $error("sampled wander value wrong");

  sample_fofs_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && reg_hit && reg_wr && reg_wdata[LQTA_SAMPLE_BIT] &&
    reg_wdata[LQTA_PSEL_HI:LQTA_PSEL_LO] == LQTA_P_FOFS
    |=> sampled == $past(param_live[31:24]))
    else $error("sampled offset value wrong");

  sample_fctl_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && reg_hit && reg_wr && reg_wdata[LQTA_SAMPLE_BIT] &&
    reg_wdata[LQTA_PSEL_HI:LQTA_PSEL_LO] == LQTA_P_FCTL
    |=> sampled == $past(param_live[39:32]))
    else $error("sampled control value wrong");

  // Threshold addressing
  thr_write_lo_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    threshold_write_strobe && reg_wdata[11:8] == 4'h8
    |=> thr_lo[4] == $past(reg_wdata[7:0]))
    else $error("low control threshold write lost");

  thr_write_mid_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    threshold_write_strobe && reg_wdata[11:8] == 4'h5
    |=> thr_hi[2] == $past(reg_wdata[7:0]))
    else $error("high wander threshold write lost");

  sel_echo_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    reg_hit |-> reg_rdata[11:9] == parameter_select && reg_rdata[8] == bound_select)
    else $error("select fields not returned");

  psel_store_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && reg_hit && reg_wr |=> parameter_select == $past(reg_wdata[11:9]))
    else $error("parameter select not stored");

  field_store_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && reg_hit && reg_wr |=> threshold_value_field == $past(reg_wdata[7:0]))
    else $error("data field not stored");

  bad_sel_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    reg_hit && !sample_mode && parameter_select > LQTA_P_FCTL |-> reg_rdata[7:0] == 8'h00)
    else $error("unused select returned data");

  // Readback of the sampled value
  samp_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    reg_hit && sample_mode |-> reg_rdata[7:0] == sampled)
    else $error("sampled value not returned");

  read_quiet_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    reg_rd && !reg_wr |=> $stable(sampled) && $stable(sample_mode))
    else $error("read disturbed the sample");

  frozen_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !clk_en |=> $stable(sampled) && $stable(thr_lo[1]) && $stable(thr_hi[1]))
    else $error("state changed with clock enable low");

  // Monitor gating and warnings
  no_enable_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !monitor_enable |-> warn_hit == '0)
    else $error("warning while monitor disabled");

  min_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    thr_lo[1] == LQTA_MIN |-> !warn_hit[2])
    else $error("disabled low check fired");

  lo_warn_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    monitor_active && thr_lo[3] != LQTA_MIN && param_live[31:24] < thr_lo[3] |-> warn_hit[6])
    else $error("low offset warning missing");

  hi_warn_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    monitor_active && thr_hi[0] != LQTA_MAX && param_live[7:0] > thr_hi[0] |-> warn_hit[1])
    else $error("high equalizer warning missing");

  wr_cover_c: cover property (@(posedge clk_sys) threshold_write_strobe);
  samp_cover_c: cover property (@(posedge clk_sys) sample_mode && reg_hit);
  pd_cover_c: cover property (@(posedge clk_sys) reg_hit && reg_wr && power_down);
  lo_cover_c: cover property (@(posedge clk_sys) warn_hit[0]);
  hi_cover_c: cover property (@(posedge clk_sys) warn_hit[1]);
endmodule

/* File: dv/lqta_test.sv */
`timescale 1ns/1ps
module lqta_test;
  import lqta_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic [4:0] reg_addr = LQTA_REG_ADDR;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic power_down = 1'b0;
  logic link_100_valid = 1'b0;
  logic monitor_enable = 1'b0;
  logic [39:0] param_live = 40'h0;
  logic monitor_active;
  logic [9:0] warn_hit;
  int mismatches = 0;
  int cmp_count = 0;
  always #10 clk_sys = ~clk_sys;
  lqta_regs u_lqta_regs (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .power_down(power_down), .link_100_valid(link_100_valid),
    .monitor_enable(monitor_enable), .param_live(param_live),
    .monitor_active(monitor_active), .warn_hit(warn_hit));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  // One register write, fields visible on return
  task automatic wr(input logic [15:0] d);
    @(posedge clk_sys);
    #1 reg_wr = 1'b1;
    reg_wdata = d;
    @(posedge clk_sys);
    #1 reg_wr = 1'b0;
  endtask
  function automatic logic [7:0] thr(input int i);
    return i[0] ? 8'hc0 + 8'(i) : 8'h20 + 8'(i);
  endfunction
  task automatic t_reset;
    check("reset read", reg_rdata, LQTA_REG_RESET);
    monitor_enable = 1'b1;
    link_100_valid = 1'b1;
    param_live = {5{8'hff}};
    #1 check("warn at max", {6'h0, warn_hit}, 16'h0000);
    param_live = {5{8'h00}};
    #1 check("warn at min", {6'h0, warn_hit}, 16'h0000);
    $display("reset test done");
  endtask
  task automatic t_thresholds;
    for (int i = 0; i < 10; i++) begin
      wr({2'b11, 2'b01, i[3:1], i[0], thr(i)});
      check("thr write", reg_rdata, {4'h0, i[3:1], i[0], thr(i)});
    end
    for (int i = 0; i < 10; i++) begin
      wr({4'h0, i[3:1], i[0], 8'h00});
      check("thr read", reg_rdata, {4'h0, i[3:1], i[0], thr(i)});
    end
    wr({4'h1, 3'h5, 1'b0, 8'h33});
    check("bad select", reg_rdata, 16'h0a00);
    $display("threshold test done");
  endtask
  task automatic t_refuse;
    power_down = 1'b1;
    wr({4'h1, 3'h0, 1'b0, 8'h77});
    power_down = 1'b0;
    check("power down", reg_rdata, 16'h0020);
    clk_en = 1'b0;
    wr(16'h1377);
    clk_en = 1'b1;
    check("no enable", reg_rdata, 16'h0020);
    reg_addr = 5'h1d;
    wr(16'h1077);
    check("other addr", reg_rdata, 16'h0000);
    reg_addr = LQTA_REG_ADDR;
    #1 check("after other", reg_rdata, 16'h0020);
    $display("refusal test done");
  endtask
  task automatic t_sample;
    logic [7:0] v;
    param_live = {8'h55, 8'h44, 8'h33, 8'h22, 8'h11};
    for (int i = 0; i < 5; i++) begin
      v = 8'h11 * 8'(i + 1);
      wr({4'h2, i[2:0], 1'b0, 8'h00});
      check("sample", reg_rdata, {4'h2, i[2:0], 1'b0, v});
    end
    param_live = ~param_live;
    @(posedge clk_sys);
    #1 check("sample held", reg_rdata, 16'h2855);
    $display("sample test done");
  endtask
  task automatic t_monitor;
    for (int i = 0; i < 4; i++) begin
      {monitor_enable, link_100_valid} = i[1:0];
      #1 check("active", {15'h0, monitor_active}, {15'h0, i == 3});
    end
    param_live = {5{8'h10}};
    #1 check("warn low", {6'h0, warn_hit}, 16'h0155);
    param_live = {5{8'hf0}};
    #1 check("warn high", {6'h0, warn_hit}, 16'h02aa);
    param_live = {5{8'h80}};
    #1 check("warn none", {6'h0, warn_hit}, 16'h0000);
    $display("monitor test done");
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    t_reset();
    t_thresholds();
    t_refuse();
    t_sample();
    t_monitor();
    end_of_test();
  end
endmodule
